// [pkg/gpb_pkg.sv]
// shared constants and carrier types for the port b/c/d general-purpose i/o block
package gpb_pkg;

  // ==========================================================================
  // widths
  localparam int GPB_B_W = 8;
  localparam int GPB_C_W = 7;
  localparam int GPB_D_W = 8;
  localparam int GPB_ADDR_W = 8;
  localparam int GPB_DATA_W = 8;
  localparam int GPB_SPI_PINS = 4;
  localparam int GPB_TIM_CHANS = 4;
  localparam int GPB_ADC_SEL_W = 3;

  // ==========================================================================
  // register offsets on the cpu register port
  localparam logic [7:0] GPB_OFS_ANALOG_DATA = 8'h01;
  localparam logic [7:0] GPB_OFS_PULLUP_DATA = 8'h02;
  localparam logic [7:0] GPB_OFS_SERTIM_DATA = 8'h03;
  localparam logic [7:0] GPB_OFS_ANALOG_DIR = 8'h10;
  localparam logic [7:0] GPB_OFS_PULLUP_DIR = 8'h11;
  localparam logic [7:0] GPB_OFS_SERTIM_DIR = 8'h12;
  localparam logic [7:0] GPB_OFS_PULLUP_PUE = 8'h13;
  localparam logic [7:0] GPB_OFS_SERTIM_PUE = 8'h14;

  // ==========================================================================
  // reset values and fixed codes
  localparam logic [7:0] GPB_DIR_RST = 8'h00;
  localparam logic [6:0] GPB_DIR_C_RST = 7'h00;
  localparam logic [7:0] GPB_PUE_RST = 8'h00;
  localparam logic [6:0] GPB_PUE_C_RST = 7'h00;
  localparam logic [7:0] GPB_RD_NONE = 8'h00;
  localparam logic [7:0] GPB_ONE_HOT_B = 8'h01;
  localparam logic [1:0] GPB_ELS_GPIO = 2'h0;

  // ==========================================================================
  // pin positions on the serial/timer port
  localparam int GPB_PIN_SLAVE_SEL = 0;
  localparam int GPB_PIN_TIM_BASE = 4;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [GPB_ADDR_W-1:0] addr;
    logic [GPB_DATA_W-1:0] wdata;
  } gpb_bus_s;

  typedef struct packed {
    logic serialPeripheralEnable;
    logic serialMasterSelect;
    logic [GPB_SPI_PINS-1:0] pinOut;
    logic [GPB_SPI_PINS-1:0] pinOe;
  } gpb_spi_s;

  typedef struct packed {
    logic [GPB_TIM_CHANS-1:0][1:0] timerEdgeLevelSelect;
    logic [GPB_TIM_CHANS-1:0] pinOut;
    logic [GPB_TIM_CHANS-1:0] pinOe;
  } gpb_tim_s;

endpackage : gpb_pkg

// [hw/gpb_port_slice.sv]
// per-port pin logic: input synchroniser, drive select, pull-up gate and read select
`timescale 1ns/10ps

module gpb_port_slice #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // port registers
  input wire logic [W-1:0] latchVal,
  input wire logic [W-1:0] dirVal,
  input wire logic [W-1:0] pullEnVal,
  // peripheral takeover
  input wire logic [W-1:0] ovrEn,
  input wire logic [W-1:0] ovrOut,
  input wire logic [W-1:0] ovrOe,
  // pads
  input wire logic [W-1:0] padIn,
  output logic [W-1:0] padOut,
  output logic [W-1:0] padOe,
  output logic [W-1:0] padPullUp,
  // synchronised level and read value
  output logic [W-1:0] pinSync,
  output logic [W-1:0] readVal
);

  // ==========================================================================
  // input synchroniser: first stage feeds only the second stage
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= padIn;
      sync_q <= meta_q;
    end
  end

  assign pinSync = sync_q;

  // ==========================================================================
  // per-pin drive and read selection
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pin
      // a peripheral that owns the pin decides the driver, else the direction bit
      assign padOe[i] = ovrEn[i] ? ovrOe[i] : dirVal[i];
      // gate the data so an unwritten latch never shows on an idle pad
      assign padOut[i] = padOe[i] & (ovrEn[i] ? ovrOut[i] : latchVal[i]);
      // pull-up drops out automatically when the direction selects output
      assign padPullUp[i] = pullEnVal[i] & ~dirVal[i] & ~ovrEn[i];
      // read choice follows the direction bit even under takeover
      assign readVal[i] = dirVal[i] ? latchVal[i] : sync_q[i];
    end
  endgenerate

endmodule : gpb_port_slice

// [hw/gpb_ports.sv]
// general-purpose i/o for the analog-shared, pull-up and serial/timer-shared ports
`timescale 1ns/10ps

module gpb_ports
  import gpb_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // cpu register port
  input wire gpb_bus_s busReq,
  output logic [GPB_DATA_W-1:0] rdData,
  output logic rdValid,
  // analog-shared port pads
  input wire logic [GPB_B_W-1:0] padInB,
  output logic [GPB_B_W-1:0] padOutB,
  output logic [GPB_B_W-1:0] padOeB,
  output logic [GPB_B_W-1:0] analogInputPins,
  // pull-up port pads
  input wire logic [GPB_C_W-1:0] padInC,
  output logic [GPB_C_W-1:0] padOutC,
  output logic [GPB_C_W-1:0] padOeC,
  output logic [GPB_C_W-1:0] padPullUpC,
  // serial/timer-shared port pads
  input wire logic [GPB_D_W-1:0] padInD,
  output logic [GPB_D_W-1:0] padOutD,
  output logic [GPB_D_W-1:0] padOeD,
  output logic [GPB_D_W-1:0] padPullUpD,
  output logic [GPB_D_W-1:0] pinLevelD,
  // peripheral controls
  input wire logic adcEnable,
  input wire logic [GPB_ADC_SEL_W-1:0] adcChannel,
  input wire gpb_spi_s spiCtl,
  input wire gpb_tim_s timCtl
);

  // ==========================================================================
  // register state
  logic [GPB_B_W-1:0] analogPortData_q;
  logic [GPB_C_W-1:0] pullupPortData_q;
  logic [GPB_D_W-1:0] serialTimerPortData_q;
  logic [GPB_B_W-1:0] analogPortDirection_q;
  logic [GPB_C_W-1:0] pullupPortDirection_q;
  logic [GPB_D_W-1:0] serialTimerPortDirection_q;
  logic [GPB_C_W-1:0] pullupPortPullupEnable_q;
  logic [GPB_D_W-1:0] serialTimerPortPullupEnable_q;
  logic [GPB_DATA_W-1:0] rdData_q;
  logic rdValid_q;

  // ==========================================================================
  // address decode
  wire wrAnaData = busReq.wr && (busReq.addr == GPB_OFS_ANALOG_DATA);
  wire wrPupData = busReq.wr && (busReq.addr == GPB_OFS_PULLUP_DATA);
  wire wrSerData = busReq.wr && (busReq.addr == GPB_OFS_SERTIM_DATA);
  wire wrAnaDir = busReq.wr && (busReq.addr == GPB_OFS_ANALOG_DIR);
  wire wrPupDir = busReq.wr && (busReq.addr == GPB_OFS_PULLUP_DIR);
  wire wrSerDir = busReq.wr && (busReq.addr == GPB_OFS_SERTIM_DIR);
  wire wrPupPue = busReq.wr && (busReq.addr == GPB_OFS_PULLUP_PUE);
  wire wrSerPue = busReq.wr && (busReq.addr == GPB_OFS_SERTIM_PUE);

  // ==========================================================================
  // data latches: no reset, a write lands whatever the direction
  always_ff @(posedge clk) begin
    if (wrAnaData) analogPortData_q <= busReq.wdata;
    if (wrPupData) pullupPortData_q <= busReq.wdata[GPB_C_W-1:0];
    if (wrSerData) serialTimerPortData_q <= busReq.wdata;
  end

  // ==========================================================================
  // direction registers come up as inputs
  always_ff @(posedge clk) begin
    if (reset) begin
      analogPortDirection_q <= GPB_DIR_RST;
      pullupPortDirection_q <= GPB_DIR_C_RST;
      serialTimerPortDirection_q <= GPB_DIR_RST;
    end else begin
      if (wrAnaDir) analogPortDirection_q <= busReq.wdata;
      if (wrPupDir) pullupPortDirection_q <= busReq.wdata[GPB_C_W-1:0];
      if (wrSerDir) serialTimerPortDirection_q <= busReq.wdata;
    end
  end

  // ==========================================================================
  // pull-up enables; cleared at reset so no pad is pulled before software asks
  always_ff @(posedge clk) begin
    if (reset) begin
      pullupPortPullupEnable_q <= GPB_PUE_C_RST;
      serialTimerPortPullupEnable_q <= GPB_PUE_RST;
    end else begin
      if (wrPupPue) pullupPortPullupEnable_q <= busReq.wdata[GPB_C_W-1:0];
      if (wrSerPue) serialTimerPortPullupEnable_q <= busReq.wdata;
    end
  end

  // ==========================================================================
  // peripheral takeover of the analog-shared port
  // the selected channel pin loses its digital driver, so an analog level is not fought
  assign analogInputPins = adcEnable ? (GPB_ONE_HOT_B << adcChannel) : '0;

  // ==========================================================================
  // peripheral takeover of the serial/timer-shared port
  logic [GPB_D_W-1:0] ovrEnD;
  logic [GPB_D_W-1:0] ovrOutD;
  logic [GPB_D_W-1:0] ovrOeD;
  wire spiOn = spiCtl.serialPeripheralEnable;
  // slave select stays plain i/o while this end is master
  wire ssTaken = spiOn && !spiCtl.serialMasterSelect;

  genvar s;
  genvar t;
  generate
    for (s = 0; s < GPB_SPI_PINS; s++) begin : g_spi
      if (s == GPB_PIN_SLAVE_SEL) begin : g_ss
        // slave select is only ever an input to the serial module
        assign ovrEnD[s] = ssTaken;
        assign ovrOutD[s] = 1'b0;
        assign ovrOeD[s] = 1'b0;
      end else begin : g_line
        assign ovrEnD[s] = spiOn;
        assign ovrOutD[s] = spiCtl.pinOut[s];
        assign ovrOeD[s] = spiCtl.pinOe[s];
      end
    end
    for (t = 0; t < GPB_TIM_CHANS; t++) begin : g_tim
      // any edge/level code other than the idle one hands the pin to the timer
      assign ovrEnD[GPB_PIN_TIM_BASE+t] = timCtl.timerEdgeLevelSelect[t] != GPB_ELS_GPIO;
      assign ovrOutD[GPB_PIN_TIM_BASE+t] = timCtl.pinOut[t];
      assign ovrOeD[GPB_PIN_TIM_BASE+t] = timCtl.pinOe[t];
    end
  endgenerate

  // ==========================================================================
  // pin slices
  logic [GPB_B_W-1:0] readB;
  logic [GPB_C_W-1:0] readC;
  logic [GPB_D_W-1:0] readD;
  logic [GPB_B_W-1:0] syncB;
  logic [GPB_C_W-1:0] syncC;

  // analog port: no pull-ups, analog select forces the driver off
  gpb_port_slice #(.W(GPB_B_W)) u_analog (
    .clk(clk),
    .reset(reset),
    .latchVal(analogPortData_q),
    .dirVal(analogPortDirection_q),
    .pullEnVal('0),
    .ovrEn(analogInputPins),
    .ovrOut('0),
    .ovrOe('0),
    .padIn(padInB),
    .padOut(padOutB),
    .padOe(padOeB),
    .padPullUp(),
    .pinSync(syncB),
    .readVal(readB)
  );

  // pull-up port: plain i/o with pull-ups
  gpb_port_slice #(.W(GPB_C_W)) u_pullup (
    .clk(clk),
    .reset(reset),
    .latchVal(pullupPortData_q),
    .dirVal(pullupPortDirection_q),
    .pullEnVal(pullupPortPullupEnable_q),
    .ovrEn('0),
    .ovrOut('0),
    .ovrOe('0),
    .padIn(padInC),
    .padOut(padOutC),
    .padOe(padOeC),
    .padPullUp(padPullUpC),
    .pinSync(syncC),
    .readVal(readC)
  );

  // serial/timer port: takeover drives, direction still picks read source
  gpb_port_slice #(.W(GPB_D_W)) u_sertim (
    .clk(clk),
    .reset(reset),
    .latchVal(serialTimerPortData_q),
    .dirVal(serialTimerPortDirection_q),
    .pullEnVal(serialTimerPortPullupEnable_q),
    .ovrEn(ovrEnD),
    .ovrOut(ovrOutD),
    .ovrOe(ovrOeD),
    .padIn(padInD),
    .padOut(padOutD),
    .padOe(padOeD),
    .padPullUp(padPullUpD),
    .pinSync(pinLevelD),
    .readVal(readD)
  );

  // ==========================================================================
  // read select; unmapped offsets read as zero
  wire [GPB_DATA_W-1:0] rdMux =
    (busReq.addr == GPB_OFS_ANALOG_DATA) ? readB :
    (busReq.addr == GPB_OFS_PULLUP_DATA) ? {1'b0, readC} :
    (busReq.addr == GPB_OFS_SERTIM_DATA) ? readD :
    (busReq.addr == GPB_OFS_ANALOG_DIR) ? analogPortDirection_q :
    (busReq.addr == GPB_OFS_PULLUP_DIR) ? {1'b0, pullupPortDirection_q} :
    (busReq.addr == GPB_OFS_SERTIM_DIR) ? serialTimerPortDirection_q :
    (busReq.addr == GPB_OFS_PULLUP_PUE) ? {1'b0, pullupPortPullupEnable_q} :
    (busReq.addr == GPB_OFS_SERTIM_PUE) ? serialTimerPortPullupEnable_q :
    GPB_RD_NONE;

  // read answer one cycle after the strobe, held until the next read
  always_ff @(posedge clk) begin
    if (reset) begin
      rdData_q <= GPB_RD_NONE;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= busReq.rd;
      if (busReq.rd) rdData_q <= rdMux;
    end
  end

  assign rdData = rdData_q;
  assign rdValid = rdValid_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_rd(logic [7:0] ofs);
    busReq.rd && busReq.addr == ofs;
  endsequence

  sequence s_padB_steady;
    $stable(padInB) [*3];
  endsequence

  a_anadir_reset: assert property ($fell(reset) |-> analogPortDirection_q == GPB_DIR_RST)
    else $error("analog port direction not cleared by reset");
  a_pupdir_reset: assert property ($fell(reset) |-> pullupPortDirection_q == GPB_DIR_C_RST)
    else $error("pull-up port direction not cleared by reset");
  a_serdir_reset: assert property ($fell(reset) |->
      serialTimerPortDirection_q == GPB_DIR_RST)
    else $error("serial/timer port direction not cleared by reset");
  a_latch_write: assert property (wrAnaData |=> analogPortData_q == $past(busReq.wdata))
    else $error("analog latch write lost");
  // reset is not a disable here on purpose: the latches must ride through it untouched
  a_latch_hold: assert property (disable iff (1'b0)
      reset && !wrAnaData && !wrPupData && !wrSerData |=>
      {analogPortData_q, pullupPortData_q, serialTimerPortData_q} ===
      $past({analogPortData_q, pullupPortData_q, serialTimerPortData_q}))
    else $error("reset disturbed a port data latch");
  a_anadrive_dir: assert property (!adcEnable |-> padOeB == analogPortDirection_q)
    else $error("analog port driver does not follow direction");
  a_analog_force: assert property (adcEnable |->
      !padOeB[adcChannel] && analogInputPins[adcChannel])
    else $error("analog channel pin still driven");
  a_readb_value: assert property (s_rd(GPB_OFS_ANALOG_DATA) |=>
      rdValid && rdData == (($past(analogPortDirection_q) & $past(analogPortData_q)) |
                            (~$past(analogPortDirection_q) & $past(syncB))))
    else $error("analog port read value wrong");
  a_readc_value: assert property (s_rd(GPB_OFS_PULLUP_DATA) |=>
      rdData == {1'b0, ($past(pullupPortDirection_q) & $past(pullupPortData_q)) |
                       (~$past(pullupPortDirection_q) & $past(syncC))})
    else $error("pull-up port read value wrong");
  a_readd_value: assert property (s_rd(GPB_OFS_SERTIM_DATA) |=>
      rdData == (($past(serialTimerPortDirection_q) & $past(serialTimerPortData_q)) |
                 (~$past(serialTimerPortDirection_q) & $past(pinLevelD))))
    else $error("serial/timer port read value wrong");
  a_pullup_gate: assert property (padPullUpC ==
      (pullupPortPullupEnable_q & ~pullupPortDirection_q))
    else $error("pull-up active on an output pin");
  a_spi_off_gpio: assert property (!spiOn |->
      padOeD[GPB_SPI_PINS-1:0] == serialTimerPortDirection_q[GPB_SPI_PINS-1:0])
    else $error("serial pins not plain i/o while serial disabled");
  a_ss_slave: assert property (ssTaken |-> !padOeD[GPB_PIN_SLAVE_SEL])
    else $error("slave select driven while owned by serial module");
  // the serial module's own drive must reach its pins whatever the direction bits say
  a_spi_drive: assert property (spiOn |->
      padOeD[GPB_SPI_PINS-1:GPB_PIN_SLAVE_SEL+1] ==
      spiCtl.pinOe[GPB_SPI_PINS-1:GPB_PIN_SLAVE_SEL+1])
    else $error("serial-owned pins not driven by the serial module");
  a_timer_pin: assert property (timCtl.timerEdgeLevelSelect[0] != GPB_ELS_GPIO |->
      padOeD[GPB_PIN_TIM_BASE] == timCtl.pinOe[0])
    else $error("timer channel pin not under timer control");
  a_pad_sync: assert property ((s_padB_steady ##0 s_rd(GPB_OFS_ANALOG_DATA) ##0
      (analogPortDirection_q == GPB_DIR_RST && !adcEnable)) |=> rdData == $past(padInB, 3))
    else $error("synchronised pin level wrong on read");

endmodule : gpb_ports

// [tb/gpb_pad_model.sv]
// pad-side partner: resolves each pad from design drive, outside drive and pull-up
`timescale 1ns/10ps

module gpb_pad_model #(
  parameter int W = 8
) (
  // clock
  input wire logic clk,
  // design side of the pads
  input wire logic [W-1:0] padOut,
  input wire logic [W-1:0] padOe,
  input wire logic [W-1:0] padPullUp,
  // outside driver, weaker than the design's own buffer
  input wire logic [W-1:0] extVal,
  input wire logic [W-1:0] extEn,
  // resolved level back into the design
  output logic [W-1:0] padIn
);
  logic [W-1:0] wander_q = '0;

  // an undriven, unpulled pad wanders so that a stale value never passes for a real one
  always @(posedge clk) wander_q <= ~wander_q;

  // design drive wins, then the outside world, then the pull-up
  assign padIn = (padOe & padOut) | (~padOe & extEn & extVal)
    | (~padOe & ~extEn & (padPullUp | (~padPullUp & wander_q)));
endmodule : gpb_pad_model

// [tb/gpb_ports_b_c_d_tb.sv]
// self-checking bench for the port b/c/d general-purpose i/o block
`timescale 1ns/10ps

module gpb_ports_b_c_d_tb
  import gpb_pkg::*;
;
  // ==========================================================================
  // design, pads and bench state
  logic clk = 1'b0;
  logic reset = 1'b1;
  gpb_bus_s busReq = '0;
  logic [7:0] rdData;
  logic rdValid;
  logic [7:0] padInB, padOutB, padOeB, analogInputPins;
  logic [6:0] padInC, padOutC, padOeC, padPullUpC;
  logic [7:0] padInD, padOutD, padOeD, padPullUpD, pinLevelD;
  logic adcEnable = 1'b0;
  logic [2:0] adcChannel = 3'h0;
  gpb_spi_s spiCtl = '0;
  gpb_tim_s timCtl = '0;
  logic [7:0] latB, latC, latD, dirB, dirC, dirD, pueC, pueD, v;
  logic [7:0] extB, extC, extD, enB, enC, enD;
  int fails = 0;
  int totalChecks = 0;
  localparam logic [7:0] OFS [9] = '{GPB_OFS_ANALOG_DATA, GPB_OFS_PULLUP_DATA,
    GPB_OFS_SERTIM_DATA, GPB_OFS_ANALOG_DIR, GPB_OFS_PULLUP_DIR, GPB_OFS_SERTIM_DIR,
    GPB_OFS_PULLUP_PUE, GPB_OFS_SERTIM_PUE, 8'h7F};

  gpb_ports dut (.clk(clk), .reset(reset), .busReq(busReq), .rdData(rdData),
    .rdValid(rdValid), .padInB(padInB), .padOutB(padOutB), .padOeB(padOeB),
    .analogInputPins(analogInputPins), .padInC(padInC), .padOutC(padOutC), .padOeC(padOeC),
    .padPullUpC(padPullUpC), .padInD(padInD), .padOutD(padOutD), .padOeD(padOeD),
    .padPullUpD(padPullUpD), .pinLevelD(pinLevelD), .adcEnable(adcEnable),
    .adcChannel(adcChannel), .spiCtl(spiCtl), .timCtl(timCtl));
  gpb_pad_model #(.W(8)) padsB (.clk(clk), .padOut(padOutB), .padOe(padOeB),
    .padPullUp(8'h00), .extVal(extB), .extEn(enB), .padIn(padInB));
  gpb_pad_model #(.W(7)) padsC (.clk(clk), .padOut(padOutC), .padOe(padOeC),
    .padPullUp(padPullUpC), .extVal(extC[6:0]), .extEn(enC[6:0]), .padIn(padInC));
  gpb_pad_model #(.W(8)) padsD (.clk(clk), .padOut(padOutD), .padOe(padOeD),
    .padPullUp(padPullUpD), .extVal(extD), .extEn(enD), .padIn(padInD));

  // 100 MHz clock
  always #5 clk = ~clk;

  // ==========================================================================
  // expectations from the bench's own copy of the registers
  function automatic logic [7:0] adcMask();
    return adcEnable ? (8'h01 << adcChannel) : 8'h00;
  endfunction : adcMask
  function automatic logic [7:0] takeD();
    logic [7:0] t;
    t = {4'h0, {3{spiCtl.serialPeripheralEnable}},
      spiCtl.serialPeripheralEnable & ~spiCtl.serialMasterSelect};
    for (int k = 0; k < 4; k++) t[4+k] = timCtl.timerEdgeLevelSelect[k] != 2'h0;
    return t;
  endfunction : takeD
  function automatic logic [7:0] oeD();
    return (dirD & ~takeD()) | ({timCtl.pinOe, spiCtl.pinOe[3:1], 1'b0} & takeD());
  endfunction : oeD
  function automatic logic [7:0] outD();
    return ((latD & ~takeD()) | ({timCtl.pinOut, spiCtl.pinOut[3:1], 1'b0} & takeD())) & oeD();
  endfunction : outD
  function automatic logic [7:0] pullD();
    return pueD & ~dirD & ~takeD();
  endfunction : pullD
  function automatic logic [7:0] lvl(input logic [7:0] oe, out, en, ext, pull);
    return (oe & out) | (~oe & en & ext) | (~oe & ~en & pull);
  endfunction : lvl
  function automatic logic [7:0] expReg(input logic [7:0] a);
    case (a)
      GPB_OFS_ANALOG_DATA: return (dirB & latB) | (~dirB & lvl(dirB & ~adcMask(), latB, enB,
        extB, 8'h00));
      GPB_OFS_PULLUP_DATA: return ((dirC & latC) | (~dirC & lvl(dirC, latC, enC, extC,
        pueC & ~dirC))) & 8'h7F;
      GPB_OFS_SERTIM_DATA: return (dirD & latD) | (~dirD & lvl(oeD(), outD(), enD, extD, pullD()));
      GPB_OFS_ANALOG_DIR: return dirB;
      GPB_OFS_PULLUP_DIR: return dirC;
      GPB_OFS_SERTIM_DIR: return dirD;
      GPB_OFS_PULLUP_PUE: return pueC;
      GPB_OFS_SERTIM_PUE: return pueD;
      default: return 8'h00;
    endcase
  endfunction : expReg

  // ==========================================================================
  // comparison, bus cycles and the closing report
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d, mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  // strobe held for exactly one edge, then a released cycle before the next request
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) busReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) busReq <= '0;
    case (a)
      GPB_OFS_ANALOG_DATA: latB = d;
      GPB_OFS_PULLUP_DATA: latC = d & 8'h7F;
      GPB_OFS_SERTIM_DATA: latD = d;
      GPB_OFS_ANALOG_DIR: dirB = d;
      GPB_OFS_PULLUP_DIR: dirC = d & 8'h7F;
      GPB_OFS_SERTIM_DIR: dirD = d;
      GPB_OFS_PULLUP_PUE: pueC = d & 8'h7F;
      GPB_OFS_SERTIM_PUE: pueD = d;
      default: ;
    endcase
  endtask : wrReg
  // the valid flag stands for one cycle only, so it is looked at right after the taking edge
  task automatic readAll();
    for (int i = 0; i < 9; i++) begin
      @(posedge clk) busReq <= '{wr: 1'b0, rd: 1'b1, addr: OFS[i], wdata: 8'h00};
      @(posedge clk) busReq <= '0;
      #1;
      check("read valid", {7'h00, rdValid}, 8'h01);
      check($sformatf("read %h", OFS[i]), rdData, expReg(OFS[i]));
    end
  endtask : readAll
  // pulled pins may be released by the outside world; the rest stay driven so levels are known
  task automatic setExt();
    @(posedge clk);
    extB <= 8'($urandom);
    extC <= 8'($urandom);
    extD <= 8'($urandom);
    enB <= 8'hFF;
    enC <= 8'($urandom) | ~(pueC & ~dirC);
    enD <= 8'($urandom) | ~pullD();
    repeat (3) @(posedge clk);
    #1;
  endtask : setExt
  task automatic checkPads();
    check("oe b", padOeB, dirB & ~adcMask());
    check("out b", padOutB & padOeB, latB & dirB & ~adcMask());
    check("analog select", analogInputPins, adcMask());
    check("oe c", {1'b0, padOeC}, dirC);
    check("out c", {1'b0, padOutC & padOeC}, latC & dirC);
    check("pull c", {1'b0, padPullUpC}, pueC & ~dirC);
    check("oe d", padOeD, oeD());
    check("out d", padOutD & padOeD, outD());
    check("pull d", padPullUpD, pullD());
    check("level d", pinLevelD, lvl(oeD(), outD(), enD, extD, pullD()));
  endtask : checkPads

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    summarize();
  end

  // main sequence: reset state, random traffic, then a reset in mid-run
  initial begin
    {extB, extC, extD} = '0;
    {enB, enC, enD} = '1;
    {dirB, dirC, dirD, pueC, pueD} = '0;
    v = 8'($urandom(35));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    setExt();
    checkPads();
    readAll();
    for (int n = 0; n < 40; n++) begin
      // latches go before directions so a pin never turns to output on stale data
      for (int i = 0; i < 9; i++) wrReg(OFS[i], 8'($urandom));
      @(posedge clk);
      adcEnable <= 1'($urandom);
      adcChannel <= 3'($urandom);
      {spiCtl, timCtl} <= 26'($urandom);
      setExt();
      checkPads();
      readAll();
    end
    // latches must survive a reset in mid-run; only direction and pull-up state clears
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    {dirB, dirC, dirD, pueC, pueD} = '0;
    setExt();
    checkPads();
    readAll();
    for (int i = 3; i < 6; i++) wrReg(OFS[i], 8'hFF);
    setExt();
    readAll();
    summarize();
  end
endmodule : gpb_ports_b_c_d_tb
